// *** verilog/flash_pin_map.vh ***
`ifndef FLASH_PIN_MAP_VH
`define FLASH_PIN_MAP_VH
// ==========================================================
// What this block and its host must do
// (RQ1) Capture inputs on serial clock rise, DDR on both
// (RQ2) Launch SDR on fall, DDR on both
// (RQ3) Deselected: ignore inputs, outputs high impedance
// (RQ4) Busy bit high while internal operation runs
// (RQ5) Select low is active; deselect idle is standby
// (RQ6) Host gives select fall before first command
// (RQ7) Line zero bidirectional in dual and quad
// (RQ8) Single output on fall; line one bidirectional
// (RQ9) Protect low with disable bit drops writes
// (RQ10) Quad enable turns protect pin into line two
// (RQ11) Shared reset only quad off or deselected
// (RQ12) Quad and selected: line three is data only
// (RQ13) Shared reset needs select high, pulse time
// (RQ14) Host drives line three high ending writes
// (RQ15) Device drives line three high after reads
// (RQ16) Reset enable zero ignores shared reset pin
// (RQ17) Dedicated reset low pulse starts hardware reset
// (RQ18) Hardware reset ends within recovery period
// (RQ19) Host leaves shared reset unused with dedicated
// (RQ20) No shared reset line among quad memories
// (RQ21) No commands accepted during reset recovery
// (RQ22) Protect only when quad off, disable bit set
// ==========================================================

// Timing
`define CLK_PERIOD_NS 100
`define RESET_PULSE_NS 200
`define RESET_RECOVERY_NS 35000
`define SELECT_HIGH_NS 50

// Register field positions
`define QUAD_ENABLE_BIT 1
`define RESET_ENABLE_BIT 5
`define WRITE_DISABLE_BIT 7
`define WIP_BIT 1

// Bus widths
`define WIDTH_SINGLE 2'h0
`define WIDTH_DUAL 2'h1
`define WIDTH_QUAD 2'h2

// Synchroniser reset values: sck low, csN and resetN high, lines 2 and 3 pulled up
`define PIN_SYNC_RESET 7'h3C
`endif

// *** verilog/pin_sync.v ***
// ==========================================================
// Two-stage synchroniser
module pin_sync #(
	parameter WIDTH = 7,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Data
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stageOne_ff;
	reg [WIDTH-1:0] stageTwo_ff;

	always @(posedge sys_clk) begin
		if (rst) begin
			stageOne_ff <= RESET_VALUE;
			stageTwo_ff <= RESET_VALUE;
		end else begin
			stageOne_ff <= asyncIn;
			stageTwo_ff <= stageOne_ff;
		end
	end

	assign syncOut = stageTwo_ff;
endmodule

// *** verilog/low_pulse_timer.v ***
// ==========================================================
// One pulse once a condition has held COUNT cycles
module low_pulse_timer #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] COUNT = 8'h02
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Condition and result
	input wire cond,
	output wire fired
);
	reg [WIDTH-1:0] cnt_ff;
	reg [WIDTH-1:0] nxt_cnt;
	reg fired_ff;

	always @* begin
		nxt_cnt = cnt_ff;
		if (!cond) begin
			nxt_cnt = {WIDTH{1'b0}};
		end else if (cnt_ff != COUNT) begin
			nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff <= {WIDTH{1'b0}};
			fired_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			fired_ff <= cond && (cnt_ff == COUNT - {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end

	assign fired = fired_ff;
endmodule

// *** verilog/serial_flash_pin_interface.v ***
`include "flash_pin_map.vh"
// ==========================================================
// Pin-level front end of a multi-line serial flash port
module serial_flash_pin_interface #(
	parameter CNT_WIDTH = 12
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Serial pins
	input wire sck,
	input wire csN,
	input wire resetN,
	input wire [3:0] dataIn,
	output wire [3:0] dataOut,
	output wire [3:0] dataOe,
	// Register bits from the core
	input wire [7:0] configOneVolatile,
	input wire [7:0] configTwoVolatile,
	input wire [7:0] statusOneNonvolatile,
	// Transfer control from the core
	input wire [1:0] busWidth,
	input wire ddrMode,
	input wire txEnable,
	input wire [3:0] txData,
	input wire readTransfer,
	input wire opBusy,
	input wire regWriteCmd,
	// Status to the core
	output wire [3:0] rxData,
	output wire rxValid,
	output wire rxOnFall,
	output wire txReq,
	output wire selected,
	output wire standby,
	output wire writeInProgress,
	output wire regWriteBlocked,
	output wire hwResetPulse,
	output wire resetBusy,
	output wire firstSelectSeen
);
	// ==========================================================
	// Timing counts
	localparam integer PULSE_CYC_I = (`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam integer RECOV_CYC_I = `RESET_RECOVERY_NS / `CLK_PERIOD_NS;
	localparam integer HOLD_CYC_I = (`SELECT_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam [CNT_WIDTH-1:0] CNT_ONE = {{(CNT_WIDTH-1){1'b0}}, 1'b1};
	localparam [CNT_WIDTH-1:0] PULSE_CYC = PULSE_CYC_I < 1 ? CNT_ONE : PULSE_CYC_I[CNT_WIDTH-1:0];
	localparam [CNT_WIDTH-1:0] RECOV_CYC = RECOV_CYC_I < 1 ? CNT_ONE : RECOV_CYC_I[CNT_WIDTH-1:0];
	localparam [CNT_WIDTH-1:0] HOLD_CYC = HOLD_CYC_I < 1 ? CNT_ONE : HOLD_CYC_I[CNT_WIDTH-1:0];

	// ==========================================================
	// Lane mask per bus width
	function [3:0] laneMask;
		input [1:0] width;
		begin
			case (width)
				`WIDTH_DUAL: laneMask = 4'h3;
				`WIDTH_QUAD: laneMask = 4'hF;
				default: laneMask = 4'h1;
			endcase
		end
	endfunction

	// ==========================================================
	// Pin synchronisers
	wire [6:0] pinSync;
	wire sckS;
	wire csNS;
	wire resetNS;
	wire [3:0] dataS;

	pin_sync #(
		.WIDTH(7),
		.RESET_VALUE(`PIN_SYNC_RESET)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.asyncIn({sck, csN, resetN, dataIn}),
		.syncOut(pinSync)
	);

	assign sckS = pinSync[6];
	assign csNS = pinSync[5];
	assign resetNS = pinSync[4];
	assign dataS = pinSync[3:0];

	// ==========================================================
	// Edge detection on synchronised pins
	reg sckPrev_ff;
	reg csNPrev_ff;
	wire sckRise;
	wire sckFall;
	wire csFall;
	wire csRise;

	always @(posedge sys_clk) begin
		if (rst) begin
			sckPrev_ff <= 1'b0;
			csNPrev_ff <= 1'b1;
		end else begin
			sckPrev_ff <= sckS;
			csNPrev_ff <= csNS;
		end
	end

	assign sckRise = sckS && !sckPrev_ff;
	assign sckFall = !sckS && sckPrev_ff;
	assign csFall = !csNS && csNPrev_ff;
	assign csRise = csNS && !csNPrev_ff;

	// ==========================================================
	// Mode bits
	wire quadOn;
	wire resetOn;
	wire writeDisable;

	assign quadOn = configOneVolatile[`QUAD_ENABLE_BIT];
	assign resetOn = configTwoVolatile[`RESET_ENABLE_BIT];
	assign writeDisable = statusOneNonvolatile[`WRITE_DISABLE_BIT];

	// ==========================================================
	// Reset pulse detection
	reg resetBusy_ff;
	reg [3:0] dataOe_ff;
	wire dedicatedFired;
	wire sharedFired;
	wire sharedCond;

	low_pulse_timer #(
		.WIDTH(CNT_WIDTH),
		.COUNT(PULSE_CYC)
	) u_dedicated_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.cond(!resetNS),
		.fired(dedicatedFired)
	); // see (RQ17)

	// Line three as reset: enabled, deselected, not driven by us
	assign sharedCond = resetOn && csNS && !dataS[3] && !dataOe_ff[3]; // see (RQ11) see (RQ16)

	low_pulse_timer #(
		.WIDTH(CNT_WIDTH),
		.COUNT(PULSE_CYC)
	) u_shared_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.cond(sharedCond),
		.fired(sharedFired)
	); // see (RQ12) see (RQ13)

	// ==========================================================
	// Hardware reset recovery
	reg [CNT_WIDTH-1:0] recov_ff;
	reg [CNT_WIDTH-1:0] nxt_recov;
	reg hwResetPulse_ff;
	reg nxt_resetBusy;
	wire resetStart;

	assign resetStart = dedicatedFired || sharedFired;

	always @* begin
		nxt_recov = recov_ff;
		nxt_resetBusy = resetBusy_ff;
		if (resetStart) begin
			nxt_recov = RECOV_CYC;
			nxt_resetBusy = 1'b1; // see (RQ17)
		end else if (resetBusy_ff) begin
			nxt_recov = recov_ff - CNT_ONE;
			if (recov_ff == CNT_ONE) begin
				nxt_resetBusy = 1'b0; // see (RQ18)
			end
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			recov_ff <= {CNT_WIDTH{1'b0}};
			resetBusy_ff <= 1'b0;
			hwResetPulse_ff <= 1'b0;
		end else begin
			recov_ff <= nxt_recov;
			resetBusy_ff <= nxt_resetBusy;
			hwResetPulse_ff <= resetStart;
		end
	end

	// ==========================================================
	// Select tracking
	reg armed_ff;
	reg selected_ff;
	reg standby_ff;
	reg wip_ff;
	wire live;

	always @(posedge sys_clk) begin
		if (rst) begin
			armed_ff <= 1'b0;
			selected_ff <= 1'b0;
			standby_ff <= 1'b1;
			wip_ff <= 1'b0;
		end else begin
			// A fresh select fall is needed after power-up or reset
			if (resetStart) begin
				armed_ff <= 1'b0;
			end else if (csFall && !resetBusy_ff) begin
				armed_ff <= 1'b1; // see (RQ6)
			end
			selected_ff <= !csNS && !resetBusy_ff; // see (RQ5)
			standby_ff <= csNS && !opBusy && !resetBusy_ff; // see (RQ5)
			wip_ff <= opBusy; // see (RQ4)
		end
	end

	// Commands only while selected, armed and out of reset
	assign live = !csNS && armed_ff && !resetBusy_ff; // see (RQ3) see (RQ21)

	// ==========================================================
	// Input capture
	reg [3:0] rxData_ff;
	reg rxValid_ff;
	reg rxOnFall_ff;
	wire capture;

	assign capture = live && !txEnable && (sckRise || (ddrMode && sckFall)); // see (RQ1)

	always @(posedge sys_clk) begin
		if (rst) begin
			rxData_ff <= 4'h0;
			rxValid_ff <= 1'b0;
			rxOnFall_ff <= 1'b0;
		end else begin
			rxValid_ff <= capture;
			if (capture) begin
				rxData_ff <= dataS & laneMask(busWidth); // see (RQ7) see (RQ10)
				rxOnFall_ff <= sckFall;
			end
		end
	end

	// ==========================================================
	// Write-protect check
	reg blocked_ff;

	always @(posedge sys_clk) begin
		if (rst) begin
			blocked_ff <= 1'b0;
		end else begin
			// Protect pin low during a register write drops it silently when the disable bit is set and quad is off
			blocked_ff <= regWriteCmd && writeDisable && !quadOn && !dataS[2]; // see (RQ9) see (RQ22)
		end
	end

	// ==========================================================
	// Output launch
	reg [3:0] dataOut_ff;
	reg [3:0] nxt_dataOut;
	reg [3:0] nxt_dataOe;
	reg txReq_ff;
	reg readSeen_ff;
	reg [CNT_WIDTH-1:0] hold_ff;
	reg [CNT_WIDTH-1:0] nxt_hold;
	wire launch;
	wire driving;

	assign driving = live && txEnable;
	assign launch = driving && (sckFall || (ddrMode && sckRise)); // see (RQ2)

	always @* begin
		nxt_hold = hold_ff;
		if (csRise && readSeen_ff && !resetBusy_ff) begin
			nxt_hold = HOLD_CYC; // see (RQ15)
		end else if (!csNS || resetStart) begin
			nxt_hold = {CNT_WIDTH{1'b0}};
		end else if (hold_ff != {CNT_WIDTH{1'b0}}) begin
			nxt_hold = hold_ff - CNT_ONE;
		end
	end

	always @* begin
		nxt_dataOut = dataOut_ff;
		nxt_dataOe = 4'h0;
		if (csNS) begin
			// Deselected: only the line three hold after a read
			if (nxt_hold != {CNT_WIDTH{1'b0}}) begin
				nxt_dataOe = 4'h8; // see (RQ15)
				nxt_dataOut = 4'h8;
			end
		end else if (driving) begin
			nxt_dataOe = laneMask(busWidth); // see (RQ7) see (RQ10)
			if (busWidth == `WIDTH_SINGLE) begin
				nxt_dataOe = 4'h2; // see (RQ8)
			end
			if (launch) begin
				if (busWidth == `WIDTH_SINGLE) begin
					nxt_dataOut = {2'h0, txData[0], 1'b0}; // see (RQ8)
				end else begin
					nxt_dataOut = txData & laneMask(busWidth);
				end
			end
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			dataOut_ff <= 4'h0;
			dataOe_ff <= 4'h0;
			txReq_ff <= 1'b0;
			readSeen_ff <= 1'b0;
			hold_ff <= {CNT_WIDTH{1'b0}};
		end else begin
			dataOut_ff <= nxt_dataOut;
			dataOe_ff <= nxt_dataOe; // see (RQ3)
			txReq_ff <= launch;
			hold_ff <= nxt_hold;
			if (csFall) begin
				readSeen_ff <= 1'b0;
			end else if (driving && readTransfer) begin
				readSeen_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Outputs
	assign dataOut = dataOut_ff;
	assign dataOe = dataOe_ff;
	assign rxData = rxData_ff;
	assign rxValid = rxValid_ff;
	assign rxOnFall = rxOnFall_ff;
	assign txReq = txReq_ff;
	assign selected = selected_ff;
	assign standby = standby_ff;
	assign writeInProgress = wip_ff;
	assign regWriteBlocked = blocked_ff;
	assign hwResetPulse = hwResetPulse_ff;
	assign resetBusy = resetBusy_ff;
	assign firstSelectSeen = armed_ff;
endmodule

// *** sim/spi_host_model.sv ***
// ====
// Host side of the serial pins
module spi_host_model (
	// Clock
	input wire logic sys_clk,
	// Pins
	output logic sck,
	output logic csN,
	output wire logic [3:0] dataIn,
	input wire logic [3:0] dataOut,
	input wire logic [3:0] dataOe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] val = 4'hF;
	logic [3:0] oe = 4'hC;
	logic flip = 1'b0;
	always @(posedge sys_clk) flip <= !flip;
	// Released lines: pull-up on 2 and 3, toggling on 0 and 1
	assign dataIn = (dataOe & dataOut) | (~dataOe & oe & val)
		| (~dataOe & ~oe & {2'h3, flip, !flip});
	initial begin
		sck = 1'b0;
		csN = 1'b1;
	end
	task automatic sel(input logic low);
		csN = !low;
	endtask
	task automatic desel;
		val[3] = 1'b1;
		oe[3] = 1'b1;
		csN = 1'b1;
	endtask
	task automatic beat(input logic [3:0] v);
		val = v;
		#400 sck = 1'b1;
		#400 sck = 1'b0;
	endtask
endmodule

// *** sim/serial_flash_pin_interface_chk.sv ***
module serial_flash_pin_interface_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Watched ports
	input wire logic sck,
	input wire logic csN,
	input wire logic resetN,
	input wire logic [3:0] dataIn,
	input wire logic [3:0] dataOe,
	input wire logic [7:0] configOneVolatile,
	input wire logic [7:0] configTwoVolatile,
	input wire logic [7:0] statusOneNonvolatile,
	input wire logic ddrMode,
	input wire logic opBusy,
	input wire logic regWriteCmd,
	input wire logic rxValid,
	input wire logic rxOnFall,
	input wire logic txReq,
	input wire logic standby,
	input wire logic writeInProgress,
	input wire logic regWriteBlocked,
	input wire logic hwResetPulse,
	input wire logic resetBusy
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RECOV_MAX = 400;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence resetLow;
		$fell(resetN) ##1 !resetN;
	endsequence
	hi_z_a: assert property (csN [*8] |-> dataOe == 4'h0) else $error("drive");
	rise_take_a: assert property (rxValid && !ddrMode |-> sck && !rxOnFall)
		else $error("capture edge");
	fall_launch_a: assert property (txReq && !ddrMode |-> !sck) else $error("launch");
	wip_follow_a: assert property ($stable(opBusy) [*2] |-> writeInProgress == opBusy)
		else $error("busy bit");
	idle_standby_a: assert property ((csN && !opBusy && !resetBusy && !hwResetPulse) [*5]
		|-> standby) else $error("standby");
	protect_drop_a: assert property ((regWriteCmd && statusOneNonvolatile[7]
		&& !configOneVolatile[1] && !dataIn[2]) [*4] |-> regWriteBlocked) else $error("protect");
	quad_free_a: assert property ((configOneVolatile[1] || !statusOneNonvolatile[7]) [*2]
		|-> !regWriteBlocked) else $error("unprotect");
	pin_reset_a: assert property (resetLow |-> ##[1:6] hwResetPulse) else $error("reset");
	recover_end_a: assert property (hwResetPulse |=> resetBusy [*8] ##[1:RECOV_MAX] !resetBusy)
		else $error("recovery");
	shared_gate_a: assert property ((resetN && (!configTwoVolatile[5] || !csN)) [*6]
		|-> !hwResetPulse) else $error("shared reset");
endmodule

// *** sim/serial_flash_pin_interface_bench.sv ***
module serial_flash_pin_interface_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic resetN = 1'b1;
	logic [7:0] configOneVolatile = 8'h00;
	logic [7:0] configTwoVolatile = 8'h00;
	logic [7:0] statusOneNonvolatile = 8'h00;
	logic [1:0] busWidth = 2'h0;
	logic ddrMode = 1'b0;
	logic txEnable = 1'b0;
	logic [3:0] txData = 4'h0;
	logic readTransfer = 1'b0;
	logic opBusy = 1'b0;
	logic regWriteCmd = 1'b0;
	wire sck, csN, rxValid, rxOnFall, txReq, selected, standby, writeInProgress;
	wire regWriteBlocked, hwResetPulse, resetBusy, firstSelectSeen;
	wire [3:0] dataIn, dataOut, dataOe, rxData;
	int bad_count = 0;
	int comparisons = 0;
	int caps = 0;
	int pulses = 0;
	int launches = 0;
	int c0;
	logic [3:0] v;
	spi_host_model h (.sys_clk, .sck, .csN, .dataIn, .dataOut, .dataOe);
	serial_flash_pin_interface i_dut (.sys_clk, .rst, .sck, .csN, .resetN, .dataIn, .dataOut,
		.dataOe, .configOneVolatile, .configTwoVolatile, .statusOneNonvolatile, .busWidth,
		.ddrMode, .txEnable, .txData, .readTransfer, .opBusy, .regWriteCmd, .rxData, .rxValid,
		.rxOnFall, .txReq, .selected, .standby, .writeInProgress, .regWriteBlocked,
		.hwResetPulse, .resetBusy, .firstSelectSeen);
	always @(posedge sys_clk) begin
		caps <= caps + int'(rxValid === 1'b1);
		pulses <= pulses + int'(hwResetPulse === 1'b1);
		launches <= launches + int'(txReq === 1'b1);
	end
	initial begin
		forever #50 sys_clk = !sys_clk;
	end
	// ====
	// Checking
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic await(input int n, input logic idle);
		for (int i = 0; i < n && (idle ? resetBusy : hwResetPulse) !== !idle; i++) tick(1);
		check(idle ? resetBusy : hwResetPulse, !idle);
		if (bad_count > 0) report_and_stop();
	endtask
	function automatic logic [3:0] lanes(input logic [3:0] d, input logic [1:0] w);
		return w == 2'h2 ? d : (w == 2'h1 ? d & 4'h3 : d & 4'h1);
	endfunction
	// ====
	// Sequence
	initial begin
		v = 4'($urandom(32'h85A9));
		configOneVolatile = 8'($urandom) & 8'hFD;
		configTwoVolatile = 8'($urandom) & 8'hDF;
		statusOneNonvolatile = 8'($urandom) & 8'h7F;
		tick(16);
		rst = 1'b0;
		h.sel(1'b1);
		tick(4);
		check(selected, 1'b1);
		h.oe = 4'hF;
		for (int w = 0; w < 4; w++) begin
			busWidth = 2'(w);
			readTransfer = 1'($urandom);
			repeat (4) begin
				v = 4'($urandom);
				h.beat(v);
				check(rxData, lanes(v, busWidth));
			end
		end
		$display("Capture test done");
		tick(4);
		ddrMode = 1'b1;
		c0 = caps;
		h.beat(4'($urandom));
		tick(4);
		check(8'(caps - c0), 8'h02);
		check(rxOnFall, 1'b1);
		ddrMode = 1'b0;
		busWidth = 2'h0;
		txEnable = 1'b1;
		readTransfer = 1'b1;
		h.oe = 4'hD;
		c0 = launches;
		repeat (4) begin
			txData = 4'($urandom);
			h.beat(4'hF);
			tick(4);
			check(dataIn[1], txData[0]);
			check(dataOe, 4'h2);
		end
		check(8'(launches - c0), 8'h04);
		h.oe = 4'h5;
		h.sel(1'b0);
		for (int i = 0; i < 8 && dataOe[3] !== 1'b1; i++) tick(1);
		check(dataOut[3] & dataOe[3], 1'b1);
		if (bad_count > 0) report_and_stop();
		tick(6);
		check(dataOe, 4'h0);
		txEnable = 1'b0;
		readTransfer = 1'b0;
		$display("Output test done");
		h.oe = 4'hF;
		h.sel(1'b1);
		for (int k = 0; k < 16; k++) begin
			regWriteCmd = !k[3];
			statusOneNonvolatile[7] = k[0];
			configOneVolatile[1] = k[1];
			h.val[2] = k[2];
			tick(5);
			check(regWriteBlocked, !k[3] & k[0] & !k[1] & !k[2]);
		end
		configOneVolatile[1] = 1'b0;
		h.desel();
		repeat (6) begin
			opBusy = 1'($urandom);
			tick(4);
			check(writeInProgress, opBusy);
			check(standby, !opBusy);
		end
		opBusy = 1'b0;
		$display("Status test done");
		configTwoVolatile[5] = 1'b1;
		h.val = 4'h7;
		await(12, 1'b0);
		h.val = 4'hF;
		await(500, 1'b1);
		configTwoVolatile[5] = 1'b0;
		c0 = pulses;
		h.val = 4'h7;
		tick(10);
		check(8'(pulses - c0), 8'h00);
		h.sel(1'b1);
		tick(4);
		configOneVolatile[1] = 1'b1;
		configTwoVolatile[5] = 1'b1;
		tick(10);
		check(8'(pulses - c0), 8'h00);
		h.val = 4'hF;
		tick(4);
		configOneVolatile[1] = 1'b0;
		configTwoVolatile[5] = 1'b0;
		resetN = 1'b0;
		await(12, 1'b0);
		tick(6);
		resetN = 1'b1;
		c0 = caps;
		h.beat(4'h1);
		check(8'(caps - c0), 8'h00);
		await(500, 1'b1);
		check(firstSelectSeen, 1'b0);
		h.beat(4'h1);
		check(8'(caps - c0), 8'h00);
		h.desel();
		h.beat(4'h1);
		check(8'(caps - c0), 8'h00);
		h.sel(1'b1);
		tick(4);
		check(firstSelectSeen, 1'b1);
		h.beat(4'h1);
		check(8'(caps - c0), 8'h01);
		$display("Reset test done");
		report_and_stop();
	end
endmodule
bind serial_flash_pin_interface serial_flash_pin_interface_chk i_chk (.sys_clk, .rst, .sck, .csN,
	.resetN, .dataIn, .dataOe, .configOneVolatile, .configTwoVolatile, .statusOneNonvolatile,
	.ddrMode, .opBusy, .regWriteCmd, .rxValid, .rxOnFall, .txReq, .standby, .writeInProgress,
	.regWriteBlocked, .hwResetPulse, .resetBusy);
